//--- fpes_defs.svh
// Constants for the flash program/erase host controller.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef FPES_DEFS_SVH
`define FPES_DEFS_SVH
`define FPES_CLK_NS 8
`define FPES_PROG_MAX_NS 100000
`define FPES_PROG_TMO_CYC ((`FPES_PROG_MAX_NS) / (`FPES_CLK_NS))
`define FPES_ERASE_MAX_MS 2000
`define FPES_ERASE_TMO_CYC ((`FPES_ERASE_MAX_MS) * 125000)
`define FPES_RSP_NS 4000
`define FPES_RSP_CYC (((`FPES_RSP_NS) + (`FPES_CLK_NS) - 1) / (`FPES_CLK_NS))
`define FPES_WR_CYC 8
`define FPES_RD_CYC 10
`define FPES_REG_CTRL 4'h0
`define FPES_REG_ADDR 4'h1
`define FPES_REG_DATA 4'h2
`define FPES_REG_STAT 4'h3
`define FPES_REG_RDAT 4'h4
`define FPES_OP_PROG 3'h1
`define FPES_OP_ERASE 3'h2
`define FPES_OP_PROT 3'h3
`define FPES_OP_UNPROT 3'h4
`define FPES_OP_RDSTAT 3'h5
`define FPES_ST_BUSY 0
`define FPES_ST_DONE 1
`define FPES_ST_TMO 2
`define FPES_ST_SUSP 3
`define FPES_BIT_POLL 7
`define FPES_BIT_TOG 6
`define FPES_BIT_SUSTOG 2
`define FPES_PROT_SEL 6
`endif

//--- fpes_pkg.sv
// Types for the flash program/erase host controller.
// Assumes the constants header is included by users.
package fpes_pkg;
   typedef enum logic [3:0] {
      FPES_IDLE = 4'b0000,
      FPES_UNPR = 4'b0001,
      FPES_WRLO = 4'b0010,
      FPES_WRHI = 4'b0011,
      FPES_RD1 = 4'b0100,
      FPES_RD2 = 4'b0101,
      FPES_RDW = 4'b0110,
      FPES_POLL = 4'b0111,
      FPES_HOLD = 4'b1000
   } fpes_state_t;

   typedef struct packed {
      logic [21:0] addr;
      logic [15:0] dout;
      logic doe;
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic rst_hv;
   } fpes_pins_t;
endpackage

//--- fpes_count.sv
// Down counter used for pulse widths and timeouts.
// Assumes load and enable are synchronous to the core clock.
`timescale 1ns/1ps
module fpes_count (
   // Clock, reset and enable
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Control
   input wire logic i_load,
   input wire logic [31:0] i_value,
   // Status
   output logic o_zero
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (i_load) begin
         cnt_d = i_value;
      end else if (cnt_q != 32'h0) begin
         cnt_d = cnt_q - 32'h1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         cnt_q <= 32'h0;
      end else if (i_ce) begin
         cnt_q <= cnt_d;
      end
   end

   assign o_zero = (cnt_q == 32'h0);
endmodule

//--- fpes_host.sv
// Host controller that programs, erases and protects a parallel NOR flash die.
// Assumes flash pins synchronous to i_core_clk; board lifts rst_hv to the unprotect voltage.
// What this block does
// - Host separates successive status reads by pulsing output enable.
// - Protect: select bit low, address bit one high, bit zero low.
// - Unprotect: select bit high, address bit one high, bit zero low.
// - Program command is four write cycles, with or without unprotect, outside program time.
// - Hold reset at unprotect voltage 4 us before writes.
// - Keep reset elevated 4 us after ready returns high, or 4 us after a busy timeout.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "fpes_defs.svh"
module fpes_host (
   // Clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_en,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Flash pins
   output logic [21:0] o_fl_addr,
   output logic [15:0] o_fl_dq_out,
   output logic o_fl_dq_oe,
   input wire logic [15:0] i_fl_dq_in,
   output logic o_fl_ce_n,
   output logic o_fl_oe_n,
   output logic o_fl_we_n,
   output logic o_fl_rst_hv,
   input wire logic i_fl_ready_busy_out
);
   typedef struct packed {
      fpes_pkg::fpes_state_t st;
      fpes_pkg::fpes_pins_t pins;
      logic [2:0] op;
      logic [1:0] idx;
      logic [21:0] addr;
      logic [15:0] wdata;
      logic [15:0] rd1;
      logic [15:0] rdat;
      logic [3:0] stat;
      logic unprot;
      logic [31:0] rdq;
      logic ld;
      logic [31:0] ldv;
   } fpes_st_t;

   fpes_st_t s_q;
   fpes_st_t s_d;
   logic tmo_zero;
   logic pw_zero;
   logic [31:0] tmo_val;
   logic ld_tmo;
   logic [21:0] cyc_a;
   logic [15:0] cyc_d;
   logic [1:0] ncyc;

   // Timeout for the busy phase, loaded after the last command write
   fpes_count u_tmo (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_en),
      .i_load(ld_tmo),
      .i_value(tmo_val),
      .o_zero(tmo_zero)
   );
   // Pin pulse widths and unprotect setup/hold
   // Loaded on the entering edge, so a state lasts its load plus one cycle
   fpes_count u_pw (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ce(i_en),
      .i_load(s_d.ld),
      .i_value(s_d.ldv),
      .o_zero(pw_zero)
   );

   // Command cycles; sector protect uses the select address bit
   always_comb begin
      cyc_a = 22'h000555;
      cyc_d = 16'h00AA;
      ncyc = 2'h3;
      unique case (s_q.idx)
         2'h0: begin
            cyc_a = 22'h000555;
            cyc_d = 16'h00AA;
         end
         2'h1: begin
            cyc_a = 22'h0002AA;
            cyc_d = 16'h0055;
         end
         2'h2: begin
            cyc_a = (s_q.op == `FPES_OP_PROG) ? 22'h000555 : s_q.addr;
            cyc_d = (s_q.op == `FPES_OP_PROG) ? 16'h00A0 : 16'h0030;
         end
         2'h3: begin
            cyc_a = s_q.addr;
            cyc_d = s_q.wdata;
         end
      endcase
      if (s_q.op == `FPES_OP_PROG && s_q.unprot) begin
         ncyc = 2'h3;
      end
      if (s_q.op == `FPES_OP_PROT || s_q.op == `FPES_OP_UNPROT) begin
         cyc_a = {s_q.addr[21:7], (s_q.op == `FPES_OP_UNPROT), 4'h0, 2'b10};
         cyc_d = 16'h0060;
         ncyc = 2'h0;
      end
      if (s_q.op == `FPES_OP_ERASE) begin
         ncyc = 2'h2;
      end
   end

   always_comb begin
      s_d = s_q;
      s_d.ld = 1'b0;
      s_d.ldv = 32'h0;
      ld_tmo = 1'b0;
      tmo_val = `FPES_PROG_TMO_CYC;
      o_reg_rdata = s_q.rdq;
      s_d.rdq = 32'h0;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            `FPES_REG_ADDR: s_d.rdq = {10'h0, s_q.addr};
            `FPES_REG_DATA: s_d.rdq = {16'h0, s_q.wdata};
            `FPES_REG_STAT: s_d.rdq = {27'h0, i_fl_ready_busy_out, s_q.stat};
            `FPES_REG_RDAT: s_d.rdq = {16'h0, s_q.rdat};
            `FPES_REG_CTRL: s_d.rdq = {28'h0, s_q.unprot, s_q.op};
            default: s_d.rdq = 32'h0;
         endcase
      end
      if (i_reg_wr && s_q.st == fpes_pkg::FPES_IDLE) begin
         unique case (i_reg_addr)
            `FPES_REG_ADDR: s_d.addr = i_reg_wdata[21:0];
            `FPES_REG_DATA: s_d.wdata = i_reg_wdata[15:0];
            `FPES_REG_CTRL: begin
               s_d.op = i_reg_wdata[2:0];
               s_d.unprot = i_reg_wdata[3];
               s_d.idx = 2'h0;
               s_d.stat = 4'h0;
               if (i_reg_wdata[2:0] != 3'h0) begin
                  s_d.stat[`FPES_ST_BUSY] = 1'b1;
                  s_d.pins.rst_hv = i_reg_wdata[3];
                  s_d.ld = 1'b1;
                  s_d.ldv = i_reg_wdata[3] ? `FPES_RSP_CYC : 32'h1;
                  s_d.st = (i_reg_wdata[2:0] == `FPES_OP_RDSTAT) ?
                     fpes_pkg::FPES_RD1 : fpes_pkg::FPES_UNPR;
               end
            end
            default: ;
         endcase
      end
      unique case (s_q.st)
         fpes_pkg::FPES_IDLE: ;
         fpes_pkg::FPES_UNPR: if (pw_zero) begin
            s_d.st = fpes_pkg::FPES_WRLO;
         end
         fpes_pkg::FPES_WRLO: if (pw_zero) begin
            s_d.pins.addr = cyc_a;
            s_d.pins.dout = cyc_d;
            s_d.pins.doe = 1'b1;
            s_d.pins.ce_n = 1'b0;
            s_d.pins.we_n = 1'b0;
            s_d.ld = 1'b1;
            s_d.ldv = 32'(`FPES_WR_CYC - 1);
            s_d.st = fpes_pkg::FPES_WRHI;
         end
         fpes_pkg::FPES_WRHI: if (pw_zero) begin
            s_d.pins.we_n = 1'b1;
            s_d.pins.ce_n = 1'b1;
            s_d.ld = 1'b1;
            s_d.ldv = 32'(`FPES_WR_CYC - 1);
            s_d.idx = s_q.idx + 2'h1;
            s_d.st = fpes_pkg::FPES_WRLO;
            if (s_q.idx == ncyc) begin
               s_d.pins.doe = 1'b0;
               ld_tmo = 1'b1;
               tmo_val = (s_q.op == `FPES_OP_PROG) ?
                  `FPES_PROG_TMO_CYC : `FPES_ERASE_TMO_CYC;
               s_d.st = fpes_pkg::FPES_RD1;
            end
         end
         fpes_pkg::FPES_RD1, fpes_pkg::FPES_RD2: if (pw_zero) begin
            // Any address serves for the toggle bit
            s_d.pins.ce_n = 1'b0;
            s_d.pins.oe_n = 1'b0;
            s_d.pins.addr = s_q.addr;
            s_d.ld = 1'b1;
            s_d.ldv = 32'(`FPES_RD_CYC - 1);
            s_d.st = fpes_pkg::FPES_RDW;
            if (s_q.st == fpes_pkg::FPES_RD1) begin
               s_d.idx = 2'h0;
            end
         end
         fpes_pkg::FPES_RDW: if (pw_zero) begin
            s_d.pins.oe_n = 1'b1;
            s_d.pins.ce_n = 1'b1;
            s_d.ld = 1'b1;
            s_d.ldv = 32'(`FPES_WR_CYC - 1);
            if (s_q.idx == 2'h0) begin
               s_d.rd1 = i_fl_dq_in;
            end else begin
               s_d.rdat = i_fl_dq_in;
            end
            s_d.idx = s_q.idx + 2'h1;
            s_d.st = (s_q.idx == 2'h0) ? fpes_pkg::FPES_RD2 : fpes_pkg::FPES_POLL;
         end
         fpes_pkg::FPES_POLL: begin
            // Bus is released here, so only the two latched reads are compared
            s_d.st = fpes_pkg::FPES_RD1;
            if (s_q.op == `FPES_OP_RDSTAT) begin
               // Suspend bit toggling marks an erase-suspended sector
               s_d.stat[`FPES_ST_SUSP] =
                  (s_q.rd1[`FPES_BIT_SUSTOG] != s_q.rdat[`FPES_BIT_SUSTOG]);
               s_d.stat[`FPES_ST_DONE] = 1'b1;
               s_d.st = fpes_pkg::FPES_HOLD;
            end else if (s_q.rd1[`FPES_BIT_TOG] == s_q.rdat[`FPES_BIT_TOG] &&
                         i_fl_ready_busy_out &&
                         (s_q.op != `FPES_OP_PROG ||
                          s_q.rdat[`FPES_BIT_POLL] == s_q.wdata[`FPES_BIT_POLL])) begin
               s_d.stat[`FPES_ST_DONE] = 1'b1;
               s_d.ld = 1'b1;
               s_d.ldv = s_q.unprot ? `FPES_RSP_CYC : 32'h1;
               s_d.st = fpes_pkg::FPES_HOLD;
            end else if (tmo_zero) begin
               s_d.stat[`FPES_ST_TMO] = 1'b1;
               s_d.ld = 1'b1;
               s_d.ldv = s_q.unprot ? `FPES_RSP_CYC : 32'h1;
               s_d.st = fpes_pkg::FPES_HOLD;
            end
         end
         fpes_pkg::FPES_HOLD: if (pw_zero) begin
            s_d.pins.rst_hv = 1'b0;
            s_d.stat[`FPES_ST_BUSY] = 1'b0;
            s_d.op = 3'h0;
            s_d.st = fpes_pkg::FPES_IDLE;
         end
         default: s_d.st = fpes_pkg::FPES_IDLE;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         s_q <= '0;
         s_q.pins.ce_n <= 1'b1;
         s_q.pins.oe_n <= 1'b1;
         s_q.pins.we_n <= 1'b1;
      end else if (i_en) begin
         s_q <= s_d;
      end
   end

   assign o_fl_addr = s_q.pins.addr;
   assign o_fl_dq_out = s_q.pins.dout;
   assign o_fl_dq_oe = s_q.pins.doe;
   assign o_fl_ce_n = s_q.pins.ce_n;
   assign o_fl_oe_n = s_q.pins.oe_n;
   assign o_fl_we_n = s_q.pins.we_n;
   assign o_fl_rst_hv = s_q.pins.rst_hv;
endmodule

//--- fpes_host_asserts.sv
// Port-level protocol checks for the flash host controller.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "fpes_defs.svh"
module fpes_host_asserts (
   // Clock and control
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_en,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   // Flash pins
   input wire logic [21:0] o_fl_addr,
   input wire logic [15:0] o_fl_dq_out,
   input wire logic o_fl_dq_oe,
   input wire logic [15:0] i_fl_dq_in,
   input wire logic o_fl_ce_n,
   input wire logic o_fl_oe_n,
   input wire logic o_fl_we_n,
   input wire logic o_fl_rst_hv,
   input wire logic i_fl_ready_busy_out
);
   logic [2:0] op_q;
   logic [9:0] hv_q;
   logic [9:0] rb_q;
   // Saturating, so long holds never wrap back under the limit
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         op_q <= '0;
         hv_q <= '0;
         rb_q <= '0;
      end else begin
         if (i_en && i_reg_wr && i_reg_addr == `FPES_REG_CTRL) op_q <= i_reg_wdata[2:0];
         hv_q <= !o_fl_rst_hv ? '0 : (hv_q == 10'h3FF ? hv_q : hv_q + 10'h1);
         rb_q <= !(o_fl_rst_hv && i_fl_ready_busy_out) ? '0 :
            (rb_q == 10'h3FF ? rb_q : rb_q + 10'h1);
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   sequence s_wr_low;
      (!o_fl_we_n && !o_fl_ce_n && o_fl_dq_oe)[*8];
   endsequence
   sequence s_rd_low;
      (!o_fl_oe_n && !o_fl_ce_n && !o_fl_dq_oe)[*8] ##1 (!o_fl_oe_n)[*2];
   endsequence
   property p_wr_pulse; $fell(o_fl_we_n) |-> s_wr_low ##1 o_fl_we_n; endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("write strobe width wrong");
   property p_wr_hold; $fell(o_fl_we_n) |=> ($stable(o_fl_addr) && $stable(o_fl_dq_out))[*7]; endproperty
   a_wr_hold: assert property (p_wr_hold)
      else $error("write address or data moved");
   property p_rd_pulse; $fell(o_fl_oe_n) |-> s_rd_low ##1 o_fl_oe_n; endproperty
   a_rd_pulse: assert property (p_rd_pulse)
      else $error("read strobe width wrong");
   property p_rd_gap; $rose(o_fl_oe_n) |-> o_fl_oe_n[*8]; endproperty
   a_rd_gap: assert property (p_rd_gap)
      else $error("status reads not separated");
   property p_prot_addr;
      $fell(o_fl_we_n) && (op_q == `FPES_OP_PROT || op_q == `FPES_OP_UNPROT)
         |-> o_fl_addr[1:0] == 2'h2 && o_fl_addr[6] == (op_q == `FPES_OP_UNPROT);
   endproperty
   a_prot_addr: assert property (p_prot_addr)
      else $error("protect address bits wrong");
   property p_hv_setup; $fell(o_fl_we_n) && o_fl_rst_hv |-> hv_q >= `FPES_RSP_CYC; endproperty
   a_hv_setup: assert property (p_hv_setup)
      else $error("write too soon after raising reset");
   property p_hv_hold; $fell(o_fl_rst_hv) |-> rb_q >= `FPES_RSP_CYC; endproperty
   a_hv_hold: assert property (p_hv_hold)
      else $error("reset lowered too soon after ready");
   property p_rst; $fell(i_rst) |-> o_fl_we_n && o_fl_oe_n && o_fl_ce_n && !o_fl_rst_hv; endproperty
   a_rst: assert property (p_rst)
      else $error("pins not idle after reset");
endmodule
bind fpes_host fpes_host_asserts fpes_host_asserts_i (
   .i_core_clk(i_core_clk),
   .i_rst(i_rst),
   .i_en(i_en),
   .i_reg_addr(i_reg_addr),
   .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata),
   .o_fl_addr(o_fl_addr),
   .o_fl_dq_out(o_fl_dq_out),
   .o_fl_dq_oe(o_fl_dq_oe),
   .i_fl_dq_in(i_fl_dq_in),
   .o_fl_ce_n(o_fl_ce_n),
   .o_fl_oe_n(o_fl_oe_n),
   .o_fl_we_n(o_fl_we_n),
   .o_fl_rst_hv(o_fl_rst_hv),
   .i_fl_ready_busy_out(i_fl_ready_busy_out)
);

//--- fpes_flash_model.sv
// Behavioural flash die seen from the host controller.
// Assumes pins change on the host clock; times are in host cycles.
`timescale 1ns/1ps
module fpes_flash_model #(
   parameter int PROG_CYC = 750,
   parameter int FAST_PROG_CYC = 500,
   parameter int ERASE_CYC = 3000,
   parameter logic [5:0] SUSP_SECT = 6'h05
) (
   // Clock and test controls
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_stall,
   input wire logic i_susp,
   input wire logic i_acceleration_input,
   // Flash pins
   input wire fpes_pkg::fpes_pins_t i_pins,
   output logic [15:0] o_dq,
   output logic o_rdy
);
   logic [21:0] wa;
   logic [15:0] wd, word, last, n_wr, val, held;
   logic we_p, oe_p, tog, st, ers;
   int busy;
   wire rd = !i_pins.ce_n && !i_pins.oe_n;
   wire here = i_susp && i_pins.addr[21:16] == SUSP_SECT;
   always @(posedge i_core_clk) begin
      we_p <= i_pins.we_n;
      oe_p <= i_pins.oe_n;
      if (!i_pins.we_n && !i_pins.ce_n) begin
         wa <= i_pins.addr;
         wd <= i_pins.dout;
      end
      if (rd) held <= val;
      if (i_rst) begin
         busy <= 0;
         n_wr <= '0;
         tog <= 1'h0;
         st <= 1'h0;
         last <= '0;
         word <= 16'hFFFF;
      end else begin
         if (busy > 0 && !i_stall) busy <= busy - 1;
         if (busy == 1 && ers && !i_stall) word <= 16'hFFFF;
         if (i_pins.we_n && !we_p) begin
            n_wr <= n_wr + 16'h1;
            last <= wd;
            if (last == 16'h00A0) begin
               word <= wd;
               busy <= i_acceleration_input ? FAST_PROG_CYC : PROG_CYC;
               ers <= 1'h0;
            end
            if (wd == 16'h0030) begin
               word <= 16'h0000;
               busy <= ERASE_CYC;
               ers <= 1'h1;
            end
         end
         if (!i_pins.oe_n && oe_p && !i_pins.ce_n) begin
            tog <= ~tog;
            if (here) st <= ~st;
         end
      end
   end
   always_comb begin
      if (busy > 0) val = {8'h00, ~word[7], tog, 3'h0, st, 2'h0};
      else val = here ? {word[15:3], st, word[1:0]} : word;
   end
   // Released bus shows the inverse so a stale value cannot pass
   assign o_dq = rd ? val : ~held;
   assign o_rdy = (busy == 0);
endmodule

//--- flash_program_erase_status_test.sv
// Register-level test of the flash host controller against a flash model.
// Assumes the checker is bound to the controller by its own file.
`timescale 1ns/1ps
`include "fpes_defs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("unexpected %s: expected %h seen %h", n, e, g); end end
module flash_program_erase_status_test;
   logic i_core_clk = 1'h0;
   logic i_rst = 1'h1;
   logic i_en = 1'h1;
   logic [3:0] i_reg_addr = 4'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'h0;
   logic i_reg_rd = 1'h0;
   logic [31:0] o_reg_rdata, s;
   logic [21:0] o_fl_addr;
   logic [15:0] o_fl_dq_out, i_fl_dq_in, n0;
   logic o_fl_dq_oe, o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_rst_hv, i_fl_ready_busy_out;
   logic stall = 1'h0;
   logic susp = 1'h0;
   logic acceleration_input = 1'h0;
   logic [31:0] cv [2] = '{32'h9, 32'h1};
   logic [31:0] dv [2] = '{32'hC3, 32'h5A3C};
   int n_errors = 0;
   int total_checks = 0;
   fpes_pkg::fpes_pins_t pins;
   assign pins = {o_fl_addr, o_fl_dq_out, o_fl_dq_oe, o_fl_ce_n, o_fl_oe_n, o_fl_we_n, o_fl_rst_hv};
   always #4 i_core_clk = ~i_core_clk;
   fpes_host fpes_host_i (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_en(i_en),
      .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd),
      .o_reg_rdata(o_reg_rdata),
      .o_fl_addr(o_fl_addr),
      .o_fl_dq_out(o_fl_dq_out),
      .o_fl_dq_oe(o_fl_dq_oe),
      .i_fl_dq_in(i_fl_dq_in),
      .o_fl_ce_n(o_fl_ce_n),
      .o_fl_oe_n(o_fl_oe_n),
      .o_fl_we_n(o_fl_we_n),
      .o_fl_rst_hv(o_fl_rst_hv),
      .i_fl_ready_busy_out(i_fl_ready_busy_out)
   );
   fpes_flash_model fpes_flash_model_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_stall(stall),
      .i_susp(susp), .i_acceleration_input(acceleration_input), .i_pins(pins),
      .o_dq(i_fl_dq_in), .o_rdy(i_fl_ready_busy_out));
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'h1;
      @(posedge i_core_clk);
      i_reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_core_clk);
      i_reg_addr <= a;
      i_reg_rd <= 1'h1;
      @(posedge i_core_clk);
      i_reg_rd <= 1'h0;
      #1 d = o_reg_rdata;
   endtask
   // Polls until idle with done or timeout; bound covers the program timeout
   task automatic run(input logic [31:0] c, a, dt, output logic [31:0] st);
      n0 = fpes_flash_model_i.n_wr;
      wr(`FPES_REG_ADDR, a);
      wr(`FPES_REG_DATA, dt);
      wr(`FPES_REG_CTRL, c);
      st = '0;
      for (int i = 0; i < 10000 && (st[0] || !(st[1] || st[2])); i++) rd(`FPES_REG_STAT, st);
      `CHK("finished", 1'h0, st[0])
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge i_core_clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (16) @(posedge i_core_clk);
      i_rst <= 1'h0;
      rd(`FPES_REG_STAT, s);
      `CHK("idle stat", 32'h10, s)
      rd(4'hF, s);
      `CHK("unmapped", 32'h0, s)
      i_en <= 1'h0;
      wr(`FPES_REG_CTRL, 32'h1);
      i_en <= 1'h1;
      rd(`FPES_REG_STAT, s);
      `CHK("frozen", 32'h10, s)
      $display("test reset done");
      for (int k = 0; k < 2; k++) begin
         acceleration_input <= (k == 1);
         run(cv[k], 32'h100 + k, dv[k], s);
         `CHK("prog stat", 3'h2, s[2:0])
         `CHK("ready", 1'h1, s[4])
         `CHK("cmd writes", 16'h4, fpes_flash_model_i.n_wr - n0)
         `CHK("word", dv[k][15:0], fpes_flash_model_i.word)
         rd(`FPES_REG_RDAT, s);
         `CHK("rdat", dv[k], s)
      end
      $display("test program done");
      run(32'h2, 32'h50000, 32'h0, s);
      `CHK("erase stat", 3'h2, s[2:0])
      `CHK("erased", 16'hFFFF, fpes_flash_model_i.word)
      `CHK("erase writes", 16'h3, fpes_flash_model_i.n_wr - n0)
      $display("test erase done");
      for (int op = 3; op <= 4; op++) begin
         run(op, 32'h0, 32'h0, s);
         `CHK("prot stat", 3'h2, s[2:0])
         `CHK("select", (op == 4) ? 1'h1 : 1'h0, fpes_flash_model_i.wa[6])
         `CHK("low bits", 2'h2, fpes_flash_model_i.wa[1:0])
      end
      $display("test protect done");
      susp <= 1'h1;
      run(32'h5, 32'h50000, 32'h0, s);
      `CHK("in sector", 1'h1, s[3])
      run(32'h5, 32'h10000, 32'h0, s);
      `CHK("out of sector", 1'h0, s[3])
      $display("test suspend done");
      stall <= 1'h1;
      run(32'h1, 32'h200, 32'h1111, s);
      `CHK("timeout stat", 3'h4, s[2:0])
      $display("test timeout done");
      end_of_test();
   end
endmodule
